// ===== clock_powerdown_sequencer.sv
// Power-down / power-up sequencer of a multi-output clock generator.
// Assumes synthesizer clock levels arrive on mclk, while the shared
// power-good / power-down pin and the PLL lock flag are asynchronous.
//
// How it works
// - Pin first means active-low power good
// - After power good seen low, pin means power-down
// - Request is async, high stops, low restarts
// - Request is synchronised before synthesizer shutdown
// - Park all outputs before disabling VCO, crystal
// - Two consecutive CPU complement edges qualify request
// - Single-ended outputs stop low at falling edge
// - Diff pairs park at complement fall, four periods
// - Mode zero: true driven high, complement floats
// - Mode one: both legs of pair float
// - Entry behaves alike at every CPU frequency
// - Stable clocks within 1.8 ms after exit
// - Floating diff pairs driven high within 300 us; here they float until their lane restarts after lock
// - All outputs enabled within few cycles after lock
// - Drive-mode bit per CPU pair, SRC, dot
`timescale 1ns/1ps
module clock_powerdown_sequencer #(
   parameter int LOCK_DEADLINE_CYC = pd_seq_pkg::PWRUP_LATENCY_CYC  // Lock deadline
) (
   input  wire logic                         mclk,           // 200 MHz clock
   input  wire logic                         rstn,           // Async reset, low
   // Avalon-MM slave
   input  wire logic [3:0]                   address,        // Byte address
   input  wire logic                         read,           // Read strobe
   input  wire logic                         write,          // Write strobe
   input  wire logic [3:0]                   byteenable,     // Byte lanes
   input  wire logic [31:0]                  writedata,      // Write data
   output logic      [31:0]                  readdata,       // Read data
   output logic                              waitrequest,    // Stall
   // Pins and synthesizer
   input  wire logic                         pg_pd_pin,      // Shared pin
   input  wire logic                         pll_lock,       // Async PLL lock
   input  wire pd_seq_pkg::synth_clk_s       synth_clk,      // Clock levels
   output logic                              osc_enable,     // Crystal osc on
   output logic                              vco_enable,     // VCOs on
   output pd_seq_pkg::diff_pads_s            diff_pads,      // Diff pad drive
   output logic      [pd_seq_pkg::N_SE-1:0]  se_out          // Single-ended
);

   localparam int ND  = pd_seq_pkg::N_DIFF;
   localparam int NS  = pd_seq_pkg::N_SE;
   localparam int NC  = pd_seq_pkg::N_CPU;
   localparam int NSR = pd_seq_pkg::N_SRC;

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   pd_seq_pkg::seq_state_e state_q;
   logic                   pin_m_q;
   logic                   pin_s_q;
   logic                   lock_m_q;
   logic                   lock_s_q;
   logic                   pg_seen_q;
   logic                   pd_req;
   logic                   cpu_clock_complement;
   logic                   cpu_clock_complement_prev_q;
   logic                   cpu_clock_complement_rise;
   logic [1:0]             edge_cnt_q;
   logic                   pd_recognised;
   logic [4:0]             mode_q;
   logic                   late_q;
   logic [31:0]            lock_cnt_q;
   logic                   lanes_en;
   logic [ND-1:0]          diff_lvl;
   logic [ND-1:0]          diff_run;
   logic [NS-1:0]          se_run;
   logic                   all_parked;
   logic                   all_running;
   logic                   ack_q;
   logic                   req_any;
   logic                   late_clr;
   logic [31:0]            status_word;

   // ---------------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------------
   // Select the power-down drive-mode bit that governs one diff lane
   function automatic logic lane_hiz(input int idx, input logic [4:0] mode);
      logic r;
      r = 1'b0;
      if (idx < NC) begin
         r = mode[pd_seq_pkg::MODE_CPU_LSB + idx];
      end else if (idx < NC + NSR) begin
         r = mode[pd_seq_pkg::MODE_SRC_BIT];
      end else begin
         r = mode[pd_seq_pkg::MODE_DOT_BIT];
      end
      return r;
   endfunction : lane_hiz

   // Decode a byte address against a register offset
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      return a == off;
   endfunction : hit

   // ---------------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------------
   // Both the shared pin and the lock flag come from outside mclk's domain
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_m_q  <= 1'b1;
         pin_s_q  <= 1'b1;
         lock_m_q <= 1'b0;
         lock_s_q <= 1'b0;
      end else begin
         pin_m_q  <= pg_pd_pin;
         pin_s_q  <= pin_m_q;
         lock_m_q <= pll_lock;
         lock_s_q <= lock_m_q;
      end
   end

   // ---------------------------------------------------------------------
   // Pin function switch
   // ---------------------------------------------------------------------
   // Once power good is seen low the pin never reverts until reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pg_seen_q <= 1'b0;
      end else if (!pin_s_q) begin
         pg_seen_q <= 1'b1;
      end
   end

   // High on the pin is a power-down request only after the switch
   assign pd_req = pg_seen_q & pin_s_q;

   // ---------------------------------------------------------------------
   // Request qualification on CPU complement edges
   // ---------------------------------------------------------------------
   // Counting clock edges, not mclk cycles, keeps entry the same at any
   // CPU frequency; the window simply scales with the CPU period
   assign cpu_clock_complement = ~synth_clk.cpu[0];
   assign cpu_clock_complement_rise            = cpu_clock_complement & ~cpu_clock_complement_prev_q;

   // A false rise right after reset is harmless: counting waits for RUN
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cpu_clock_complement_prev_q <= 1'b0;
         edge_cnt_q  <= 2'b00;
      end else begin
         cpu_clock_complement_prev_q <= cpu_clock_complement;
         if (!pd_req || state_q != pd_seq_pkg::ST_RUN) begin
            edge_cnt_q <= 2'b00;
         end else if (cpu_clock_complement_rise && edge_cnt_q < 2'(pd_seq_pkg::REQ_EDGES)) begin
            edge_cnt_q <= edge_cnt_q + 2'b01;
         end
      end
   end

   assign pd_recognised = edge_cnt_q == 2'(pd_seq_pkg::REQ_EDGES);

   // ---------------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_q <= pd_seq_pkg::ST_BOOT;
      end else begin
         unique case (state_q)
            pd_seq_pkg::ST_BOOT: begin
               if (pg_seen_q) begin
                  state_q <= pd_seq_pkg::ST_LOCK;
               end
            end
            pd_seq_pkg::ST_LOCK: begin
               // A request raised right after power good makes power-down
               // the first state; outputs are still parked here
               if (pd_req) begin
                  state_q <= pd_seq_pkg::ST_OFF;
               end else if (lock_s_q) begin
                  state_q <= pd_seq_pkg::ST_RUN;
               end
            end
            pd_seq_pkg::ST_RUN: begin
               if (pd_recognised) begin
                  state_q <= pd_seq_pkg::ST_PARK;
               end
            end
            pd_seq_pkg::ST_PARK: begin
               if (!pd_req) begin
                  state_q <= pd_seq_pkg::ST_RUN;
               end else if (all_parked) begin
                  state_q <= pd_seq_pkg::ST_OFF;
               end
            end
            pd_seq_pkg::ST_OFF: begin
               if (!pd_req) begin
                  state_q <= pd_seq_pkg::ST_LOCK;
               end
            end
            default: begin
               state_q <= pd_seq_pkg::ST_BOOT;
            end
         endcase
      end
   end

   // Oscillators stop only once every output is already parked
   // and restart at the edge that leaves OFF, before lock is awaited
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         osc_enable <= 1'b1;
         vco_enable <= 1'b1;
      end else begin
         osc_enable <= state_q != pd_seq_pkg::ST_OFF || !pd_req;
         vco_enable <= state_q != pd_seq_pkg::ST_OFF || !pd_req;
      end
   end

   // ---------------------------------------------------------------------
   // Power-up deadline watch
   // ---------------------------------------------------------------------
   // Outputs never start before lock even when late; the miss is flagged
   // The count saturates, so one lock wait flags at most once
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lock_cnt_q <= 32'h0000_0000;
      end else if (state_q != pd_seq_pkg::ST_LOCK) begin
         lock_cnt_q <= 32'h0000_0000;
      end else if (lock_cnt_q < 32'(LOCK_DEADLINE_CYC)) begin
         lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
      end
   end

   // Sticky late flag; a new miss wins over a software clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         late_q <= 1'b0;
      end else if (state_q == pd_seq_pkg::ST_LOCK && !lock_s_q
                   && lock_cnt_q == 32'(LOCK_DEADLINE_CYC) - 32'h0000_0001) begin
         late_q <= 1'b1;
      end else if (late_clr) begin
         late_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Output lanes
   // ---------------------------------------------------------------------
   // All lanes get the run request together; each starts on its own edge
   assign lanes_en = state_q == pd_seq_pkg::ST_RUN;
   assign diff_lvl = {synth_clk.dot, synth_clk.src, synth_clk.cpu};

   for (genvar i = 0; i < ND; i++) begin : g_diff
      clk_gate_lane #(
         .DIFF      (1'b1)
      ) u_lane (
         .mclk      (mclk),
         .rstn      (rstn),
         .lvl       (diff_lvl[i]),
         .en        (lanes_en),
         .hiz_mode  (lane_hiz(i, mode_q)),
         .out_q     (diff_pads.t[i]),
         .out_oe_q  (diff_pads.t_oe[i]),
         .comp_q    (diff_pads.c[i]),
         .comp_oe_q (diff_pads.c_oe[i]),
         .running_q (diff_run[i])
      );
   end

   // Single-ended lanes leave enable and complement outputs open
   for (genvar i = 0; i < NS; i++) begin : g_se
      clk_gate_lane #(
         .DIFF      (1'b0)
      ) u_lane (
         .mclk      (mclk),
         .rstn      (rstn),
         .lvl       (synth_clk.se[i]),
         .en        (lanes_en),
         .hiz_mode  (1'b0),
         .out_q     (se_out[i]),
         .out_oe_q  (),
         .comp_q    (),
         .comp_oe_q (),
         .running_q (se_run[i])
      );
   end

   assign all_parked  = ~(|diff_run) & ~(|se_run);
   assign all_running = (&diff_run) & (&se_run);

   // ---------------------------------------------------------------------
   // Avalon-MM slave
   // ---------------------------------------------------------------------
   // One wait state: every access answers at the second edge it is held
   // Of the status word only the late bit is writable, by a one
   assign req_any     = read | write;
   assign waitrequest = req_any & ~ack_q;
   assign late_clr    = write & ack_q & hit(address, pd_seq_pkg::ADDR_STATUS)
                        & byteenable[0] & writedata[pd_seq_pkg::STAT_LATE_BIT];

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[pd_seq_pkg::STAT_STATE_LSB +: 3] = state_q;
      status_word[pd_seq_pkg::STAT_PG_BIT]         = pg_seen_q;
      status_word[pd_seq_pkg::STAT_LOCK_BIT]       = lock_s_q;
      status_word[pd_seq_pkg::STAT_LATE_BIT]       = late_q;
      status_word[pd_seq_pkg::STAT_RUN_BIT]        = all_running;
      status_word[pd_seq_pkg::STAT_PARK_BIT]       = all_parked;
   end

   // Handshake and read data; unmapped addresses read as zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ack_q    <= 1'b0;
         readdata <= 32'h0000_0000;
      end else begin
         ack_q <= req_any & ~ack_q;
         if (read && !ack_q) begin
            if (hit(address, pd_seq_pkg::ADDR_MODE)) begin
               readdata <= {27'h000_0000, mode_q};
            end else if (hit(address, pd_seq_pkg::ADDR_STATUS)) begin
               readdata <= status_word;
            end else begin
               readdata <= 32'h0000_0000;
            end
         end
      end
   end

   // Drive-mode register, written at the accepting edge only
   // A new mode reaches parked pad enables on the next edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= pd_seq_pkg::MODE_RESET;
      end else if (write && ack_q && hit(address, pd_seq_pkg::ADDR_MODE)
                   && byteenable[0]) begin
         mode_q <= writedata[4:0];
      end
   end

endmodule : clock_powerdown_sequencer

// ===== pd_seq_pkg.sv
// Package for the clock power-down sequencer: output counts, register map,
// field positions, reset values, state codes and timing constants.
// Assumes a single 200 MHz control clock; all users write pd_seq_pkg::name.
package pd_seq_pkg;

   // ---------------------------------------------------------------------
   // Output population
   // ---------------------------------------------------------------------
   localparam int N_CPU  = 3;                  // CPU differential pairs
   localparam int N_SRC  = 7;                  // Serial reference pairs
   localparam int N_DIFF = N_CPU + N_SRC + 1;  // Plus the dot-clock pair
   localparam int N_SE   = 11;                 // Single-ended outputs

   // ---------------------------------------------------------------------
   // Register map (byte addresses on the Avalon-MM slave)
   // ---------------------------------------------------------------------
   localparam logic [3:0]  ADDR_MODE   = 4'h0;  // Power-down drive modes
   localparam logic [3:0]  ADDR_STATUS = 4'h4;  // Sequencer status
   localparam int          MODE_CPU_LSB = 0;    // [2:0] one bit per CPU pair
   localparam int          MODE_SRC_BIT = 3;    // One bit for all SRC pairs
   localparam int          MODE_DOT_BIT = 4;    // Dot-clock pair
   localparam logic [4:0]  MODE_RESET   = 5'h00;
   localparam int          STAT_STATE_LSB = 0;  // [2:0] sequencer state
   localparam int          STAT_PG_BIT    = 3;  // Power good has been seen
   localparam int          STAT_LOCK_BIT  = 4;  // Synchronised PLL lock
   localparam int          STAT_LATE_BIT  = 5;  // Lock missed deadline, W1C
   localparam int          STAT_RUN_BIT   = 6;  // All lanes running
   localparam int          STAT_PARK_BIT  = 7;  // All lanes parked

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 5;          // 200 MHz
   localparam int PWRUP_LATENCY_NS   = 1_800_000;  // 1.8 ms longest
   localparam int PWRUP_LATENCY_CYC  = PWRUP_LATENCY_NS / CLK_PERIOD_NS;
   localparam int REQ_EDGES          = 2;          // Qualifying CPU edges

   // ---------------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,   // Pin still acts as power-good qualifier
      ST_LOCK = 3'b001,   // Oscillators on, waiting for PLL lock
      ST_RUN  = 3'b010,   // Outputs running
      ST_PARK = 3'b011,   // Outputs stopping at their own edges
      ST_OFF  = 3'b100    // Parked, VCO and crystal oscillator off
   } seq_state_e;

   // Free-running synthesizer levels, produced on the control clock
   typedef struct packed {
      logic [N_CPU-1:0] cpu;   // True legs of CPU pairs
      logic [N_SRC-1:0] src;   // True legs of SRC pairs
      logic             dot;   // True leg of the dot-clock pair
      logic [N_SE-1:0]  se;    // Single-ended clocks
   } synth_clk_s;

   // Pad drive for all differential pairs
   typedef struct packed {
      logic [N_DIFF-1:0] t;      // True leg level
      logic [N_DIFF-1:0] t_oe;   // True leg output enable
      logic [N_DIFF-1:0] c;      // Complement leg level
      logic [N_DIFF-1:0] c_oe;   // Complement leg output enable
   } diff_pads_s;

endpackage : pd_seq_pkg

// ===== clk_gate_lane.sv
// One output lane: gates a free-running clock level so that it stops and
// restarts only on its own edges, never cutting a pulse short.
// Assumes the level comes from logic on mclk, sampled without synchroniser.
`timescale 1ns/1ps
module clk_gate_lane #(
   parameter bit DIFF = 1'b0                   // 1: differential pair lane
) (
   input  wire logic mclk,                     // Control clock
   input  wire logic rstn,                     // Async reset, active low
   input  wire logic lvl,                      // Free-running clock level
   input  wire logic en,                       // Run request
   input  wire logic hiz_mode,                 // Diff: 1 = both legs Hi-Z
   output logic      out_q,                    // Single-ended / true level
   output logic      out_oe_q,                 // True leg enable
   output logic      comp_q,                   // Complement level
   output logic      comp_oe_q,                // Complement enable
   output logic      running_q                 // Lane is passing its clock
);

   logic prev_q;
   logic park_edge;
   logic start_edge;
   logic run_d;

   // ---------------------------------------------------------------------
   // Edge choice
   // ---------------------------------------------------------------------
   // A diff lane parks when its complement falls (true rises) and restarts
   // when the complement rises, so the first pulse is always full width
   assign park_edge  = DIFF ? (~prev_q & lvl) : (prev_q & ~lvl);
   assign start_edge = DIFF ? (prev_q & ~lvl) : (~prev_q & lvl);

   // Next run state: stop and start only on the lane's own edge
   always_comb begin
      run_d = running_q;
      if (running_q && !en && park_edge) begin
         run_d = 1'b0;
      end else if (!running_q && en && start_edge) begin
         run_d = 1'b1;
      end
   end

   // Level history and run flag
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prev_q    <= 1'b0;
         running_q <= 1'b0;
      end else begin
         prev_q    <= lvl;
         running_q <= run_d;
      end
   end

   // Pad drive; a parked diff pair holds true high or floats both legs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_q     <= 1'b0;
         out_oe_q  <= 1'b0;
         comp_q    <= 1'b0;
         comp_oe_q <= 1'b0;
      end else if (DIFF) begin
         out_q     <= run_d ? lvl : 1'b1;
         out_oe_q  <= run_d | ~hiz_mode;
         comp_q    <= run_d ? ~lvl : 1'b0;
         comp_oe_q <= run_d;
      end else begin
         out_q     <= run_d & lvl;
         out_oe_q  <= 1'b1;
         comp_q    <= 1'b0;
         comp_oe_q <= 1'b0;
      end
   end

endmodule : clk_gate_lane

// ===== pd_seq_monitor.sv
// Checker for the power-down sequencer, bound to the top ports.
// Assumes synthesizer levels toggle and lock drops only while parked off.
`timescale 1ns/1ps
module pd_seq_monitor (
   input wire logic                        mclk,        // Clock
   input wire logic                        rstn,        // Reset, active low
   input wire logic                        pg_pd_pin,   // Shared pin
   input wire logic                        pll_lock,    // PLL lock
   input wire pd_seq_pkg::synth_clk_s      synth_clk,   // Source levels
   input wire logic                        osc_enable,  // Oscillator on
   input wire pd_seq_pkg::diff_pads_s      diff_pads,   // Diff pads
   input wire logic [pd_seq_pkg::N_SE-1:0] se_out       // Single-ended
);
   logic seen_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Pin edges only mean requests once power good was seen
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) seen_q <= 1'b0;
      else seen_q <= seen_q | ~pg_pd_pin;
   end
   // A gated output never shows a high that its source did not have
   a_se_no_runt: assert property ((se_out & ~$past(synth_clk.se)) == '0)
      else $error("single-ended high without source level");
   a_park_levels: assert property (!osc_enable |-> se_out == '0 && (&diff_pads.t)
      && diff_pads.c_oe == '0) else $error("oscillator off before outputs parked");
   a_two_edge_qual: assert property ($rose(pg_pd_pin) && seen_q |-> osc_enable [*4])
      else $error("request acted on too early");
   a_entry_bound: assert property ($rose(pg_pd_pin) && seen_q |-> ##[1:40] !osc_enable)
      else $error("power-down entry too slow");
   a_wake_bound: assert property ($fell(pg_pd_pin) && seen_q |-> ##[1:8] osc_enable)
      else $error("oscillator not restarted");
   a_restart_bound: assert property ($rose(pll_lock) && seen_q && !pg_pd_pin
      |-> ##[1:40] se_out != '0) else $error("outputs not restarted");
   a_hiz_redrive: assert property ($rose(pll_lock) && seen_q && !pg_pd_pin
      |-> ##[1:40] (&diff_pads.t_oe)) else $error("floating pair not driven");
   a_no_run_unlocked: assert property (!pll_lock [*4] |-> se_out == '0)
      else $error("output toggles without lock");
   c_off: cover property (!osc_enable);
   c_wake: cover property ($fell(pg_pd_pin) && seen_q);
   c_relock: cover property ($rose(pll_lock) && seen_q);
endmodule : pd_seq_monitor
bind clock_powerdown_sequencer pd_seq_monitor i_pd_seq_monitor (.mclk, .rstn, .pg_pd_pin,
   .pll_lock, .synth_clk, .osc_enable, .diff_pads, .se_out);

// ===== pd_power_manager.sv
// Model of the system power manager driving the shared pin.
// Assumes the bench asks for power-down through want_pd.
`timescale 1ns/1ps
module pd_power_manager (
   input  wire logic mclk,       // Clock
   input  wire logic rstn,       // Reset, active low
   input  wire logic want_pd,    // Power-down wanted
   output logic      pg_pd_pin   // Shared pin
);
   int cnt_q;
   // Not good at first, then good, then the pin carries the request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_q     <= 0;
         pg_pd_pin <= 1'b1;
      end else begin
         cnt_q     <= cnt_q + 32'(cnt_q < 20);
         pg_pd_pin <= cnt_q < 10 || (cnt_q == 20 && want_pd);
      end
   end
endmodule : pd_power_manager

// ===== test_clock_powerdown_sequencer.sv
// Self-checking bench: bus, synthesizer levels, lock and power manager.
// Assumes one 200 MHz clock and a short lock deadline.
`timescale 1ns/1ps
module test_clock_powerdown_sequencer;
   logic                        mclk, rstn, read, write, pll_lock, want_pd, pg_pd_pin;
   logic                        osc_enable, vco_enable, waitrequest;
   logic [3:0]                  address, byteenable;
   logic [31:0]                 writedata, readdata, q;
   logic [7:0]                  cnt;
   logic [pd_seq_pkg::N_SE-1:0] se_out;
   pd_seq_pkg::diff_pads_s      diff_pads;
   pd_seq_pkg::synth_clk_s      synth_clk;
   int                          failures, n_compared, sh, m, k;
   // Free-running levels; CPU rate selectable
   assign synth_clk = {{3{cnt[sh]}}, {7{cnt[1]}}, cnt[0], {11{cnt[2]}}};
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) cnt <= cnt + 8'h01;
   clock_powerdown_sequencer #(.LOCK_DEADLINE_CYC(50)) i_clock_powerdown_sequencer (.mclk,
      .rstn, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
      .pg_pd_pin, .pll_lock, .synth_clk, .osc_enable, .vco_enable, .diff_pads, .se_out);
   pd_power_manager i_pd_power_manager (.mclk, .rstn, .want_pd, .pg_pd_pin);
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task automatic stop_test;
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   // One bus access, held until waitrequest is low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      read      <= !w;
      write     <= w;
      address   <= a;
      writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      cmp("bus wait", 1, 32'(n < 20));
      if (n >= 20) stop_test();
   endtask : bus
   // Bounded wait: 0 osc off, 1 osc on, 2 se running, 3 all true legs driven
   task automatic wait_until(input int sel);
      int   n;
      logic ok;
      n  = 0;
      ok = 1'b0;
      while (!ok && n < 400) begin
         @(posedge mclk);
         n++;
         ok = sel == 0 ? osc_enable === 1'b0 : sel == 1 ? osc_enable === 1'b1
            : sel == 2 ? (|se_out) === 1'b1 : (&diff_pads.t_oe) === 1'b1;
      end
      cmp("wait", 1, 32'(ok));
      if (!ok) stop_test();
   endtask : wait_until
   // Expected true-leg enables while parked, from the mode bits
   function automatic int exp_toe(input int md);
      int e;
      e = 0;
      for (int i = 0; i < pd_seq_pkg::N_DIFF; i++)
         e |= (((md >> (i < 3 ? i : i < 10 ? 3 : 4)) & 1) ^ 1) << i;
      return e;
   endfunction : exp_toe
   // Boot, lock, then power-down cycles over modes and CPU rates
   initial begin
      {mclk, rstn, read, write, pll_lock, want_pd} = '0;
      {address, writedata, cnt, failures, n_compared} = '0;
      byteenable = 4'hf;
      sh = 1;
      void'($urandom(32'hf5313db2));
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      bus(0, pd_seq_pkg::ADDR_STATUS, 0);
      cmp("boot status", 0, q & 32'h0000_000f);
      bus(0, pd_seq_pkg::ADDR_MODE, 0);
      cmp("mode reset", 0, q);
      bus(1, 4'h8, 32'h0000_00ff);
      bus(0, 4'h8, 0);
      cmp("unmapped", 0, q);
      repeat (20 + $urandom % 8) @(posedge mclk);
      pll_lock <= 1'b1;
      wait_until(2);
      for (k = 0; k < 4; k++) begin
         sh = 1 + k % 2;
         m  = k == 0 ? 0 : k == 1 ? 31 : $urandom % 32;
         bus(1, pd_seq_pkg::ADDR_MODE, m);
         bus(0, pd_seq_pkg::ADDR_MODE, 0);
         cmp("mode", m, q);
         want_pd <= 1'b1;
         wait_until(0);
         bus(0, pd_seq_pkg::ADDR_STATUS, 0);
         cmp("off status", 32'h0000_008c, q & 32'h0000_008f);
         cmp("true enables", exp_toe(m), 32'(diff_pads.t_oe));
         cmp("complement enables", 0, 32'(diff_pads.c_oe));
         cmp("parked se", 0, 32'(se_out));
         cmp("vco off", 0, 32'(vco_enable));
         pll_lock <= 1'b0;
         want_pd  <= 1'b0;
         wait_until(1);
         cmp("vco on", 1, 32'(vco_enable));
         repeat (5 + $urandom % 16) @(posedge mclk);
         pll_lock <= 1'b1;
         wait_until(2);
         wait_until(3);
         bus(0, pd_seq_pkg::ADDR_STATUS, 0);
         cmp("run state", 2, q & 32'h0000_0007);
      end
      // Reset again with the request held: power-down is the first state
      rstn     <= 1'b0;
      want_pd  <= 1'b1;
      pll_lock <= 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      wait_until(0);
      bus(0, pd_seq_pkg::ADDR_STATUS, 0);
      cmp("first off", 32'h0000_008c, q & 32'h0000_009f);
      // Lock held back past the deadline sets the sticky late flag
      want_pd <= 1'b0;
      wait_until(1);
      repeat (60) @(posedge mclk);
      bus(0, pd_seq_pkg::ADDR_STATUS, 0);
      cmp("late flag", 32'h0000_0029, q & 32'h0000_002f);
      bus(1, pd_seq_pkg::ADDR_STATUS, 32'h0000_0020);
      bus(0, pd_seq_pkg::ADDR_STATUS, 0);
      cmp("late clear", 32'h0000_0009, q & 32'h0000_002f);
      pll_lock <= 1'b1;
      wait_until(2);
      stop_test();
   end
endmodule : test_clock_powerdown_sequencer
